// File: design/timer_pkg.sv
// package of constants for the reloadable timer
// assumes a single 10 MHz system clock and synchronous active-high reset
// Functional notes
// - one-shot counts prescaled clock up to reload
// - one-shot match: interrupt, load 0001H, disable
// - one-shot output inverts for one cycle
// - clocked modes use prescaled system clock
// - continuous match: interrupt, load 0001H, continue
// - counting modes toggle output at each reload
// - written start count applies to first pass
// - continuous period is reload times divisor
// - counter mode counts timer input pin edges
// - polarity bit selects rising or falling edge
// - counter mode bypasses prescaler entirely
// - polarity sets initial output in counter modes
// - counter match: interrupt, reload 0001H, resume
// - comparator mode counts comparator edges, no prescale
// - comparator match: interrupt, reload 0001H, continue
// - count minus start equals counted edges
// - FFFFH without match wraps to 0000H
// - divisors 1 to 128; reload 0000H longest
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_ONE_SHOT = 2'h0,
    MODE_CONTINUOUS = 2'h1,
    MODE_COUNTER = 2'h2,
    MODE_CMP_COUNTER = 2'h3
  } timer_mode_t;
  localparam int COUNT_W = 16;
  localparam logic [15:0] COUNT_RELOAD = 16'h0001;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam int PRESCALE_SEL_W = 3;
  localparam int PRESCALE_CNT_W = 7;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
  localparam int SYNC_STAGES = 2;
endpackage

// File: design/timer_prescaler.sv
// prescaler: tick every 2**sel enabled clocks
// assumes clear is asserted while the timer is stopped
module timer_prescaler (
  // clock and control
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic clear_i,
  input wire logic [timer_pkg::PRESCALE_SEL_W-1:0] sel_i,
  // tick
  output logic tick_o
);
  typedef struct packed {
    logic [timer_pkg::PRESCALE_CNT_W-1:0] cnt;
  } pre_state_t;
  pre_state_t s_q, s_d;
  logic [timer_pkg::PRESCALE_CNT_W-1:0] limit;

  // divisor of 1 ticks every cycle, 128 ticks every 128th
  assign limit = (timer_pkg::PRESCALE_CNT_W)'((8'h01 << sel_i) - 8'h01);
  assign tick_o = clk_en_i && !clear_i && (s_q.cnt == limit);

  always_comb begin
    s_d = s_q;
    if (clear_i || tick_o) begin
      s_d.cnt = timer_pkg::PRESCALE_RESET;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q.cnt <= timer_pkg::PRESCALE_RESET;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end
endmodule

// File: design/timer_edge_detect.sv
// two-flop synchroniser followed by a selectable edge detector
// assumes input toggles at most at a quarter of the clock rate
module timer_edge_detect (
  // clock
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // input and edge select
  input wire logic async_i,
  input wire logic rising_i,
  // outputs
  output logic level_o,
  output logic edge_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;
  sync_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = async_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
  end

  // edges come from two settled samples, never the first flop
  assign level_o = s_q.sync;
  assign edge_o = clk_en_i && (rising_i ? (s_q.sync && !s_q.prev)
                                        : (!s_q.sync && s_q.prev));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end
endmodule

// File: design/reload_timer.sv
// 16-bit reloadable up-counting timer: one-shot, continuous, pin and
// comparator event counting; control bits are plain ports
// assumes software keeps the enable low while it reconfigures
module reload_timer (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  // control
  input wire logic enable_set_i,
  input wire logic enable_clr_i,
  input wire logic [1:0] mode_i,
  input wire logic [timer_pkg::PRESCALE_SEL_W-1:0] prescale_i,
  input wire logic output_polarity_edge_select_i,
  input wire logic out_func_en_i,
  // count and reload
  input wire logic count_wr_i,
  input wire logic [timer_pkg::COUNT_W-1:0] count_wdata_i,
  input wire logic [timer_pkg::COUNT_W-1:0] reload_i,
  // external signals
  input wire logic timer_in_i,
  input wire logic comparator_i,
  // status
  output logic enabled_o,
  output logic [timer_pkg::COUNT_W-1:0] count_o,
  output logic irq_o,
  output logic timer_out_o
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic en;
    logic [timer_pkg::COUNT_W-1:0] cnt;
    logic irq;
    logic out_lvl;
    logic pulse;
  } tmr_state_t;
  tmr_state_t s_q, s_d;

  timer_pkg::timer_mode_t mode;
  logic pre_tick;
  logic pin_edge;
  logic cmp_edge;
  logic step;
  logic match;
  logic rising_sel;
  logic counting_mode;

  assign mode = timer_pkg::timer_mode_t'(mode_i);
  assign rising_sel = output_polarity_edge_select_i;
  assign counting_mode = (mode == timer_pkg::MODE_COUNTER) ||
                         (mode == timer_pkg::MODE_CMP_COUNTER);

  // ************************************************************
  // input sources
  // ************************************************************
  timer_prescaler u_pre (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .clear_i(!s_q.en),
    .sel_i(prescale_i),
    .tick_o(pre_tick)
  );

  timer_edge_detect u_pin (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .async_i(timer_in_i),
    .rising_i(rising_sel),
    .level_o(),
    .edge_o(pin_edge)
  );

  timer_edge_detect u_cmp (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .async_i(comparator_i),
    .rising_i(rising_sel),
    .level_o(),
    .edge_o(cmp_edge)
  );

  // ************************************************************
  // count step selection
  // ************************************************************
  always_comb begin
    case (mode)
      timer_pkg::MODE_ONE_SHOT: step = pre_tick;
      timer_pkg::MODE_CONTINUOUS: step = pre_tick;
      timer_pkg::MODE_COUNTER: step = pin_edge;
      timer_pkg::MODE_CMP_COUNTER: step = cmp_edge;
      default: step = 1'b0;
    endcase
  end

  // reload 0000H matches only after a full wrap: longest period
  assign match = s_q.en && step && (s_q.cnt == reload_i);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.pulse = 1'b0;
    if (count_wr_i) begin
      s_d.cnt = count_wdata_i;
    end
    if (!s_q.en) begin
      // output idles at polarity while stopped
      s_d.out_lvl = output_polarity_edge_select_i;
    end
    if (match) begin
      s_d.irq = 1'b1;
      s_d.cnt = timer_pkg::COUNT_RELOAD;
      if (mode == timer_pkg::MODE_ONE_SHOT) begin
        s_d.en = 1'b0;
        s_d.pulse = out_func_en_i;
      end else if (out_func_en_i) begin
        s_d.out_lvl = !s_q.out_lvl;
      end
    end else if (s_q.en && step) begin
      if (s_q.cnt == timer_pkg::COUNT_MAX) begin
        s_d.cnt = timer_pkg::COUNT_RESET;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
    if (enable_clr_i) begin
      s_d.en = 1'b0;
    end else if (enable_set_i) begin
      s_d.en = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else if (clk_en_i) begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign enabled_o = s_q.en;
  assign count_o = s_q.cnt;
  assign irq_o = s_q.irq;
  // one-shot pulse inverts the held level for one cycle
  assign timer_out_o = s_q.out_lvl ^ s_q.pulse;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_oneshot_stop: assert property (
    (clk_en_i && match && mode == timer_pkg::MODE_ONE_SHOT && !enable_set_i)
      |=> (!enabled_o && irq_o && count_o == 16'h0001))
    else $error("one-shot did not stop at reload");

  chk_cont_reload: assert property (
    (clk_en_i && match && mode == timer_pkg::MODE_CONTINUOUS && !enable_clr_i
      && !count_wr_i) |=> (enabled_o && irq_o && count_o == 16'h0001))
    else $error("continuous reload wrong");

  chk_pulse_width: assert property (
    (clk_en_i && match && mode == timer_pkg::MODE_ONE_SHOT && out_func_en_i)
      |=> (timer_out_o != s_q.out_lvl) ##1 (!clk_en_i || timer_out_o == s_q.out_lvl))
    else $error("one-shot output pulse not one cycle");

  chk_toggle_out: assert property (
    (clk_en_i && match && mode != timer_pkg::MODE_ONE_SHOT && out_func_en_i)
      |=> (timer_out_o != $past(timer_out_o)))
    else $error("output did not toggle at reload");

  chk_wrap_zero: assert property (
    (clk_en_i && s_q.en && step && !match && count_o == 16'hFFFF && !count_wr_i)
      |=> count_o == 16'h0000)
    else $error("counter did not wrap to zero");

  chk_edge_count: assert property (
    (clk_en_i && s_q.en && counting_mode && !step && !count_wr_i)
      |=> $stable(count_o))
    else $error("count moved without an edge");

  chk_edge_step: assert property (
    (clk_en_i && s_q.en && counting_mode && step && !match && !count_wr_i
      && count_o != 16'hFFFF) |=> count_o == $past(count_o) + 16'h0001)
    else $error("edge did not advance count by one");

  chk_idle_level: assert property (
    (clk_en_i && !s_q.en && !enable_set_i)
      |=> timer_out_o == $past(output_polarity_edge_select_i))
    else $error("idle output does not follow polarity");

  chk_irq_cause: assert property (
    irq_o |-> $past(match))
    else $error("interrupt without reload");

  cov_oneshot: cover property (match && mode == timer_pkg::MODE_ONE_SHOT);
  cov_cont: cover property (match && mode == timer_pkg::MODE_CONTINUOUS);
  cov_pin: cover property (match && mode == timer_pkg::MODE_COUNTER);
  cov_cmp: cover property (match && mode == timer_pkg::MODE_CMP_COUNTER);
endmodule

// File: verification/edge_source.sv
// model of the timer input pin and the comparator output
// assumes go_i is driven by the bench and sampled on the rising clock
module edge_source (
  // control
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic to_cmp_i,
  input wire logic [3:0] pulses_i,
  // lines
  output logic timer_in_o,
  output logic comparator_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] left_q = 5'h00;
  logic [1:0] gap_q = 2'h0;
  logic cmp_q = 1'b0;
  initial timer_in_o = 1'b0;
  initial comparator_o = 1'b0;
  assign busy_o = (left_q != 5'h00);
  // ************
  // one toggle every four clocks keeps the line at a quarter rate or below
  // ************
  always @(posedge clk_i) begin
    if (go_i && left_q == 5'h00) begin
      left_q <= {pulses_i, 1'b0};
      cmp_q <= to_cmp_i;
      gap_q <= 2'h0;
    end else if (left_q != 5'h00) begin
      gap_q <= gap_q + 2'h1;
      if (gap_q == 2'h3) begin
        left_q <= left_q - 5'h01;
        if (cmp_q) comparator_o <= ~comparator_o;
        else timer_in_o <= ~timer_in_o;
      end
    end
  end
endmodule

// File: verification/reloadable_timer_count_modes_bench.sv
// self-checking bench for the reloadable timer
// assumes the edge source model and a 10 MHz clock
module reloadable_timer_count_modes_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic set_en = 1'b0, clr_en = 1'b0, pol = 1'b0, oe = 1'b0, wr = 1'b0;
  logic go = 1'b0, to_cmp = 1'b0, seen_zero = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] ps = 3'h0;
  logic [3:0] pulses = 4'h0;
  logic [15:0] wdata = 16'h0000, reload = 16'h0000;
  logic tin, cmp, busy, enabled_o, irq_o, timer_out_o;
  logic [15:0] count_o;
  int n_fail = 0, checks_done = 0, cyc = 0, n = 0, irqs = 0;
  int pss[3] = '{0, 1, 7};

  reload_timer dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
    .enable_set_i(set_en), .enable_clr_i(clr_en), .mode_i(mode), .prescale_i(ps),
    .output_polarity_edge_select_i(pol), .out_func_en_i(oe), .count_wr_i(wr),
    .count_wdata_i(wdata), .reload_i(reload), .timer_in_i(tin), .comparator_i(cmp),
    .enabled_o(enabled_o), .count_o(count_o), .irq_o(irq_o), .timer_out_o(timer_out_o));
  edge_source src (.clk_i(clk_i), .go_i(go), .to_cmp_i(to_cmp), .pulses_i(pulses),
    .timer_in_o(tin), .comparator_o(cmp), .busy_o(busy));

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  always @(negedge clk_i) begin
    if (count_o === 16'h0000) seen_zero = 1'b1;
    if (irq_o === 1'b1) irqs++;
  end

  // ************
  // tasks
  // ************
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // disable, configure and load the count, then enable
  task automatic setup(input logic [1:0] m, input logic [2:0] p, input logic pl,
    input logic o, input logic [15:0] st, input logic [15:0] rl);
    @(negedge clk_i);
    clr_en = 1'b1;
    {mode, ps, pol, oe, wr, wdata, reload} = {m, p, pl, o, 1'b1, st, rl};
    @(negedge clk_i);
    {clr_en, wr} = 2'b00;
    @(negedge clk_i);
    set_en = 1'b1;
    @(negedge clk_i);
    set_en = 1'b0;
  endtask
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (irq_o !== 1'b1 && k < 600);
    if (k >= 600) begin
      n_fail++;
      $display("BAD %0t no interrupt", $time);
    end
  endtask
  // pulses on one line, then let the synchroniser and counter settle
  task automatic send(input logic [3:0] np, input logic c);
    @(negedge clk_i);
    {go, pulses, to_cmp} = {1'b1, np, c};
    @(negedge clk_i);
    go = 1'b0;
    for (int i = 0; i < 100 && busy; i++) @(negedge clk_i);
    repeat (5) @(negedge clk_i);
  endtask

  // ************
  // tests
  // ************
  initial begin
    repeat (8) @(negedge clk_i);
    reset_i = 1'b0;
    chk(count_o, 16'h0000);
    chk(16'(enabled_o), 16'h0000);
    foreach (pss[i]) begin
      setup(2'h1, pss[i][2:0], 1'b0, 1'b1, 16'h0002, 16'h0003);
      wait_irq(n);
      chk(count_o, 16'h0001);
      chk(16'(timer_out_o), 16'h0001);
      wait_irq(n);
      chk(16'(n), 16'(3 << pss[i]));
      chk(count_o, 16'h0001);
      chk(16'(timer_out_o), 16'h0000);
    end
    setup(2'h0, 3'h0, 1'b0, 1'b1, 16'h0001, 16'h0004);
    wait_irq(n);
    chk(16'(enabled_o), 16'h0000);
    chk(16'(timer_out_o), 16'h0001);
    @(negedge clk_i);
    chk(16'(timer_out_o), 16'h0000);
    repeat (4) @(negedge clk_i);
    chk(count_o, 16'h0001);
    setup(2'h0, 3'h0, 1'b0, 1'b1, 16'h0001, 16'h0004);
    pol = 1'b1;
    wait_irq(n);
    repeat (2) @(negedge clk_i);
    chk(16'(timer_out_o), 16'h0001);
    setup(2'h1, 3'h0, 1'b0, 1'b0, 16'hFFFE, 16'h0003);
    seen_zero = 1'b0;
    wait_irq(n);
    chk(16'(seen_zero), 16'h0001);
    setup(2'h2, 3'h0, 1'b1, 1'b1, 16'h0001, 16'h0004);
    chk(16'(timer_out_o), 16'h0001);
    send(4'h2, 1'b0);
    chk(count_o, 16'h0003);
    irqs = 0;
    // the count rests one edge at the reload value, the next edge reloads it
    send(4'h2, 1'b0);
    chk(count_o, 16'h0001);
    chk(16'(irqs), 16'h0001);
    chk(16'(timer_out_o), 16'h0000);
    setup(2'h3, 3'h0, 1'b0, 1'b0, 16'h0001, 16'h0003);
    send(4'h1, 1'b1);
    chk(count_o, 16'h0002);
    send(4'h1, 1'b0);
    chk(count_o, 16'h0002);
    irqs = 0;
    send(4'h2, 1'b1);
    chk(count_o, 16'h0001);
    chk(16'(irqs), 16'h0001);
    wrap_up();
  end
endmodule
